// *** core/asc_cfg.svh ***
/*
  constants of the coordinator join and neighbour survey control block.
  assumes it is included by bare name wherever the offsets are needed.
*/
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

`define ASC_OPT_NET_BIT 0
`define ASC_OPT_LANE_BIT 1
`define ASC_OPT_JOIN_BIT 2
`define ASC_OPT_MASK 8'h07
`define ASC_OPT_RESET 8'h00
`define ASC_FRAMING_RESET 8'h00
`define ASC_FRAMING_MAX 8'h02
`define ASC_RESULT_RESET 8'h00
`define ASC_RESULT_MAX 8'h13
`define ASC_RESULT_RSVD 8'h11
`define ASC_BCAST_ADDR 16'hffff
`define ASC_BCAST_NET 16'hffff
`define ASC_DWELL_MAX 8'h06
`define ASC_FIRST_LANE 8'h0c
`define ASC_LANE_COUNT 4'hc
`define ASC_MAX_RECORDS 3'h5
`define ASC_CR 8'h0d
`define ASC_FMT_LONG 8'h03
`define ASC_NUM_FIELDS 4'hb
`define ASC_CLK_PERIOD_NS 8
`define ASC_DWELL_UNIT_NS 15360000

`endif

// *** core/asc_pkg.sv ***
/*
  types of the coordinator join and neighbour survey control block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package asc_pkg;

  typedef enum logic [3:0] {
    ASC_CMD_RD_OPTS = 4'h0,
    ASC_CMD_WR_OPTS = 4'h1,
    ASC_CMD_RD_RESULT = 4'h2,
    ASC_CMD_RD_FRAMING = 4'h3,
    ASC_CMD_WR_FRAMING = 4'h4,
    ASC_CMD_COMMIT = 4'h5,
    ASC_CMD_PERSIST = 4'h6,
    ASC_CMD_LEAVE = 4'h7,
    ASC_CMD_SURVEY = 4'h8
  } asc_cmd_t;

  typedef struct packed {
    asc_cmd_t code;
    logic [7:0] arg;
  } asc_cmd_req_t;

  typedef struct packed {
    logic join_permitted;
    logic net_coord;
    logic reserved;
    logic batt_ext;
    logic [3:0] final_cap;
    logic [3:0] sf_order;
    logic [3:0] beacon_order;
  } asc_sf_t;

  typedef struct packed {
    logic [63:0] coord_addr;
    logic [15:0] network_number;
    logic [7:0] coord_addr_format;
    logic [7:0] rf_lane_number;
    logic [7:0] security_use;
    logic [7:0] acl_entry;
    logic [7:0] security_failure;
    asc_sf_t superframe;
    logic [7:0] gts_permit;
    logic [7:0] rssi;
    logic [23:0] timestamp;
  } asc_record_t;

  typedef struct packed {
    logic [15:0] dest_addr;
    logic [15:0] network_number;
    logic [7:0] rf_lane_number;
  } asc_beacon_req_t;

  typedef struct packed {
    logic pick_free_network_bit;
    logic pick_free_lane_bit;
    logic permit_join_bit;
    logic [7:0] host_framing_select;
  } asc_active_t;

  typedef enum logic [2:0] {
    ASC_ST_IDLE = 3'b000,
    ASC_ST_REQ = 3'b001,
    ASC_ST_DWELL = 3'b010,
    ASC_ST_EMIT = 3'b011,
    ASC_ST_END = 3'b100
  } asc_state_t;

endpackage

// *** core/asc_top.sv ***
/*
  coordinator join options, commit and persist handling, join result code,
  host framing select and the neighbour survey with its report records.
  assumes the command decoder, association engine, radio and serial
  transmitter run on i_sys_clk and keep their own handshakes.
*/
`timescale 1ns/1ns
`include "asc_cfg.svh"

// Functional notes
// - bit 0 set: pick free network number
// - bit 1 set: energy scan for lane
// - bit 2 set permits joins, clear forbids
// - options are bits 0-2, rest reserved
// - commit applies pending values and reinitialises
// - persist stores only; applied on leaving
// - result code read-only, last attempt, 0-0x13
// - 0x00 success, 0x01-0x06 survey outcomes
// - 0x07-0x0a coordinator start problems
// - 0x0b-0x10 join request failures
// - 0x11 reserved, 0x12 sync loss, 0x13 gone
// - framing select 0 to 2, default 0
// - survey requests broadcast on every lane
// - lane dwell is 2^exponent times 15.36 ms
// - total time is dwell times 12 lanes
// - one record per beacon, five at most
// - record fields in order, each CR-ended
// - address format 2 short, 3 long
// - superframe bits packed at documented places
// - rssi passed as negative dBm magnitude
// - frame API mode drops all separator CRs
module asc_top import asc_pkg::*; #(
  parameter int unsigned UNIT_CYCLES =
    `ASC_DWELL_UNIT_NS / `ASC_CLK_PERIOD_NS,
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // command exchange
  input wire logic i_cmd_valid,
  input wire asc_cmd_req_t i_cmd,
  output logic o_rsp_valid,
  output logic o_rsp_err,
  output logic [7:0] o_rsp_data,
  // operating configuration
  output asc_active_t o_active,
  output logic o_reinit,
  output logic o_persist_req,
  output logic [7:0] o_persist_opts,
  output logic [7:0] o_persist_framing,
  // association outcome
  input wire logic i_join_valid,
  input wire logic [7:0] i_join_code,
  // survey radio side
  output logic o_beacon_req_valid,
  output asc_beacon_req_t o_beacon_req,
  input wire logic i_beacon_valid,
  input wire asc_record_t i_beacon_rec,
  output logic o_survey_busy,
  // survey report bytes
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  input wire logic i_tx_ready
);

  logic rst_meta;
  logic rst_n;
  logic [7:0] pend_opts;
  logic [7:0] pend_framing;
  logic [7:0] join_result_code;
  asc_state_t state;
  asc_state_t next_state;
  logic [3:0] lane_idx;
  logic [6:0] slot_cnt;
  logic [CNT_W-1:0] unit_cnt;
  logic [2:0] dwell_exponent;
  logic [2:0] rec_cnt;
  logic [2:0] rec_idx;
  logic [3:0] fld_idx;
  logic [2:0] byte_idx;
  logic cr_phase;
  asc_record_t rec_mem [`ASC_MAX_RECORDS];

  // reset released through two flops
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  // byte count of one record field; address length follows its format
  function automatic logic [2:0] field_len(input asc_record_t r,
                                           input logic [3:0] f);
    case (f)
      4'h0: field_len = (r.coord_addr_format == `ASC_FMT_LONG) ? 3'h0 : 3'h2;
      4'h1: field_len = 3'h2;
      4'h7: field_len = 3'h2;
      4'ha: field_len = 3'h3;
      default: field_len = 3'h1;
    endcase
  endfunction
  // byte b of field f, most significant byte first
  function automatic logic [7:0] field_byte(input asc_record_t r,
                                            input logic [3:0] f,
                                            input logic [2:0] b,
                                            input logic [2:0] n);
    logic [63:0] w;
    logic [2:0] sh;
    w = 64'h0;
    sh = 3'(n - 3'h1 - b);
    case (f)
      4'h0: w = r.coord_addr;
      4'h1: w = {48'h0, r.network_number};
      4'h2: w = {56'h0, r.coord_addr_format};
      4'h3: w = {56'h0, r.rf_lane_number};
      4'h4: w = {56'h0, r.security_use};
      4'h5: w = {56'h0, r.acl_entry};
      4'h6: w = {56'h0, r.security_failure};
      4'h7: w = {48'h0, r.superframe};
      4'h8: w = {56'h0, r.gts_permit};
      4'h9: w = {56'h0, r.rssi};
      4'ha: w = {40'h0, r.timestamp};
      default: w = 64'h0;
    endcase
    field_byte = w[{sh, 3'h0} +: 8];
  endfunction
  // command decode
  wire survey_on = (state != ASC_ST_IDLE);
  wire cmd_take = i_cmd_valid && !survey_on;
  wire is_wr_opts = cmd_take && (i_cmd.code == ASC_CMD_WR_OPTS);
  wire is_wr_fr = cmd_take && (i_cmd.code == ASC_CMD_WR_FRAMING);
  wire is_commit = cmd_take && (i_cmd.code == ASC_CMD_COMMIT);
  wire is_persist = cmd_take && (i_cmd.code == ASC_CMD_PERSIST);
  wire is_leave = cmd_take && (i_cmd.code == ASC_CMD_LEAVE);
  wire is_survey = cmd_take && (i_cmd.code == ASC_CMD_SURVEY);
  wire opts_ok = (i_cmd.arg & ~`ASC_OPT_MASK) == 8'h00;
  wire fr_ok = i_cmd.arg <= `ASC_FRAMING_MAX;
  wire dwell_ok = i_cmd.arg <= `ASC_DWELL_MAX;
  wire apply_now = is_commit || is_leave;
  wire api_mode = o_active.host_framing_select != 8'h00;
  wire code_ok = (i_join_code <= `ASC_RESULT_MAX) &&
                 (i_join_code != `ASC_RESULT_RSVD);
  wire known_cmd = i_cmd.code <= ASC_CMD_SURVEY;
  wire cmd_err = i_cmd_valid && (survey_on || !known_cmd ||
                 (is_wr_opts && !opts_ok) || (is_wr_fr && !fr_ok) ||
                 (is_survey && !dwell_ok));
  wire [7:0] rd_data = (i_cmd.code == ASC_CMD_RD_OPTS) ? pend_opts :
                       (i_cmd.code == ASC_CMD_RD_RESULT) ? join_result_code :
                       (i_cmd.code == ASC_CMD_RD_FRAMING) ? pend_framing :
                       8'h00;
  // survey sequencing
  wire [6:0] slot_last = 7'((7'h1 << dwell_exponent) - 7'h1);
  wire unit_done = unit_cnt == CNT_W'(UNIT_CYCLES - 1);
  wire lane_done = unit_done && (slot_cnt == slot_last);
  wire last_lane = lane_idx == 4'(`ASC_LANE_COUNT - 4'h1);
  wire tx_free = !o_tx_valid || i_tx_ready;
  asc_record_t cur_rec;
  assign cur_rec = rec_mem[rec_idx];
  wire [2:0] cur_len = field_len(cur_rec, fld_idx);
  wire last_byte = byte_idx == 3'(cur_len - 3'h1);
  wire last_fld = fld_idx == 4'(`ASC_NUM_FIELDS - 4'h1);
  wire last_rec = rec_idx == 3'(rec_cnt - 3'h1);
  wire fld_end = cr_phase || (last_byte && api_mode);
  wire emit_done = tx_free && fld_end && last_fld && last_rec;
  wire take_beacon = (state == ASC_ST_DWELL) && i_beacon_valid &&
                     (rec_cnt < `ASC_MAX_RECORDS);
  always_comb begin
    next_state = state;
    case (state)
      ASC_ST_IDLE: begin
        if (is_survey && dwell_ok) begin
          next_state = ASC_ST_REQ;
        end
      end
      ASC_ST_REQ: begin
        next_state = ASC_ST_DWELL;
      end
      ASC_ST_DWELL: begin
        if (lane_done && last_lane) begin
          next_state = (rec_cnt == 3'h0) ? ASC_ST_END : ASC_ST_EMIT;
        end else if (lane_done) begin
          next_state = ASC_ST_REQ;
        end
      end
      ASC_ST_EMIT: begin
        if (emit_done) begin
          next_state = ASC_ST_END;
        end
      end
      ASC_ST_END: begin
        if (tx_free) begin
          next_state = ASC_ST_IDLE;
        end
      end
      default: begin
        next_state = ASC_ST_IDLE;
      end
    endcase
  end
  // pending values, commit and persist
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_opts <= `ASC_OPT_RESET;
      pend_framing <= `ASC_FRAMING_RESET;
    end else begin
      if (is_wr_opts && opts_ok) begin
        pend_opts <= i_cmd.arg & `ASC_OPT_MASK;
      end
      if (is_wr_fr && fr_ok) begin
        pend_framing <= i_cmd.arg;
      end
    end
  end
  // active values only change on commit or on leaving command mode
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_active <= '0;
      o_reinit <= 1'b0;
    end else begin
      o_reinit <= apply_now;
      if (apply_now) begin
        o_active.pick_free_network_bit <= pend_opts[`ASC_OPT_NET_BIT];
        o_active.pick_free_lane_bit <= pend_opts[`ASC_OPT_LANE_BIT];
        o_active.permit_join_bit <= pend_opts[`ASC_OPT_JOIN_BIT];
        o_active.host_framing_select <= pend_framing;
      end
    end
  end
  // storing leaves operation untouched
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_persist_req <= 1'b0;
      o_persist_opts <= `ASC_OPT_RESET;
      o_persist_framing <= `ASC_FRAMING_RESET;
    end else begin
      o_persist_req <= is_persist;
      if (is_persist) begin
        o_persist_opts <= pend_opts;
        o_persist_framing <= pend_framing;
      end
    end
  end
  // result code has no write path; codes carry meanings untouched
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      join_result_code <= `ASC_RESULT_RESET;
    end else if (i_join_valid && code_ok) begin
      join_result_code <= i_join_code;
    end
  end
  // command answers
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_err <= 1'b0;
      o_rsp_data <= 8'h00;
    end else begin
      o_rsp_valid <= i_cmd_valid;
      o_rsp_err <= cmd_err;
      o_rsp_data <= cmd_take ? rd_data : 8'h00;
    end
  end
  // survey timing: one unit counter and a slot counter per lane
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ASC_ST_IDLE;
      lane_idx <= 4'h0;
      slot_cnt <= 7'h00;
      unit_cnt <= '0;
      dwell_exponent <= 3'h0;
    end else begin
      state <= next_state;
      if (is_survey && dwell_ok) begin
        dwell_exponent <= i_cmd.arg[2:0];
        lane_idx <= 4'h0;
      end
      if (state == ASC_ST_REQ) begin
        unit_cnt <= '0;
        slot_cnt <= 7'h00;
      end else if (state == ASC_ST_DWELL) begin
        unit_cnt <= unit_done ? '0 : CNT_W'(unit_cnt + 1'b1);
        if (unit_done) begin
          slot_cnt <= 7'(slot_cnt + 7'h1);
        end
        if (lane_done) begin
          lane_idx <= 4'(lane_idx + 4'h1);
        end
      end
    end
  end

  // beacon request per lane to the broadcast address and network
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_beacon_req_valid <= 1'b0;
      o_beacon_req <= '0;
      o_survey_busy <= 1'b0;
    end else begin
      o_beacon_req_valid <= state == ASC_ST_REQ;
      o_beacon_req.dest_addr <= `ASC_BCAST_ADDR;
      o_beacon_req.network_number <= `ASC_BCAST_NET;
      o_beacon_req.rf_lane_number <= 8'(`ASC_FIRST_LANE + 8'(lane_idx));
      o_survey_busy <= next_state != ASC_ST_IDLE;
    end
  end

  // record store; beacons past the fifth are dropped
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_cnt <= 3'h0;
    end else if (is_survey && dwell_ok) begin
      rec_cnt <= 3'h0;
    end else if (take_beacon) begin
      rec_cnt <= 3'(rec_cnt + 3'h1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (take_beacon) begin
      rec_mem[rec_cnt] <= i_beacon_rec;
    end
  end

  // report serialiser: field bytes, then a CR unless in frame API mode
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_idx <= 3'h0;
      fld_idx <= 4'h0;
      byte_idx <= 3'h0;
      cr_phase <= 1'b0;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
    end else if (state == ASC_ST_EMIT && tx_free) begin
      o_tx_valid <= 1'b1;
      if (cr_phase) begin
        o_tx_byte <= `ASC_CR;
      end else begin
        o_tx_byte <= field_byte(cur_rec, fld_idx, byte_idx, cur_len);
      end
      if (!cr_phase && !last_byte) begin
        byte_idx <= 3'(byte_idx + 3'h1);
      end else if (!cr_phase && !api_mode) begin
        cr_phase <= 1'b1;
      end else begin
        cr_phase <= 1'b0;
        byte_idx <= 3'h0;
        fld_idx <= last_fld ? 4'h0 : 4'(fld_idx + 4'h1);
        if (last_fld) begin
          rec_idx <= 3'(rec_idx + 3'h1);
        end
      end
    end else if (state == ASC_ST_END && tx_free) begin
      // closing CR only in transparent mode
      o_tx_valid <= !api_mode;
      o_tx_byte <= `ASC_CR;
      rec_idx <= 3'h0;
    end else if (i_tx_ready) begin
      o_tx_valid <= 1'b0;
    end
  end

endmodule

// *** testbench/asc_top_sva.sv ***
/*
  concurrent checks on the ports of asc_top.
  assumes it is attached by the bind below and sees only top-level ports.
*/
`timescale 1ns/1ns
module asc_top_sva import asc_pkg::*; (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // command exchange
  input wire logic i_cmd_valid,
  input wire asc_cmd_req_t i_cmd,
  input wire logic o_rsp_valid,
  input wire logic o_rsp_err,
  // configuration
  input wire asc_active_t o_active,
  input wire logic o_reinit,
  input wire logic o_persist_req,
  // survey
  input wire logic o_beacon_req_valid,
  input wire asc_beacon_req_t o_beacon_req,
  input wire logic o_survey_busy,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic i_tx_ready
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  wire logic go = i_cmd_valid && !o_survey_busy;

  sequence s_take(asc_cmd_t c);
    go && i_cmd.code == c;
  endsequence
  sequence s_survey_go;
    s_take(ASC_CMD_SURVEY) ##0 i_cmd.arg <= 8'h06;
  endsequence

  AST_RSP_EVERY: assert property (i_cmd_valid |=> o_rsp_valid)
    else $error("command left without response");
  AST_RSP_ONLY: assert property (
    !i_cmd_valid |=> !o_rsp_valid && !o_reinit && !o_persist_req)
    else $error("response or pulse without command");
  AST_OPTS_RSVD: assert property (
    s_take(ASC_CMD_WR_OPTS) ##0 i_cmd.arg[7:3] != 5'h00 |=> o_rsp_err)
    else $error("reserved option bits accepted");
  AST_FRAMING_WR: assert property (
    s_take(ASC_CMD_WR_FRAMING) ##0 i_cmd.arg > 8'h02 |=> o_rsp_err)
    else $error("framing above 2 accepted");
  AST_FRAMING_ACT: assert property (
    o_active.host_framing_select <= 8'h02)
    else $error("active framing out of range");
  AST_COMMIT: assert property (
    s_take(ASC_CMD_COMMIT) |=> o_reinit && !o_rsp_err)
    else $error("commit without reinit");
  AST_PERSIST: assert property (
    s_take(ASC_CMD_PERSIST) |=> o_persist_req && !o_reinit &&
      $stable(o_active))
    else $error("persist disturbed operation");
  AST_SURVEY_FIRST: assert property (
    s_survey_go |-> ##2 o_beacon_req_valid &&
      o_beacon_req.rf_lane_number == 8'h0c)
    else $error("survey did not request first lane");
  AST_BEACON_DEST: assert property (o_beacon_req_valid |->
    o_beacon_req.dest_addr == 16'hffff &&
    o_beacon_req.network_number == 16'hffff
    && o_beacon_req.rf_lane_number inside {[8'h0c:8'h17]})
    else $error("beacon request not broadcast");
  AST_SURVEY_ARG: assert property (
    s_take(ASC_CMD_SURVEY) ##0 i_cmd.arg > 8'h06 |=>
      o_rsp_err && !o_survey_busy)
    else $error("survey exponent above 6 accepted");
  AST_BUSY_REFUSE: assert property (
    i_cmd_valid && o_survey_busy |=> o_rsp_err)
    else $error("command accepted during survey");
  AST_TX_HOLD: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("report byte dropped or changed while stalled");
endmodule

bind asc_top asc_top_sva u_sva (.i_sys_clk, .i_nrst, .i_cmd_valid, .i_cmd,
  .o_rsp_valid, .o_rsp_err, .o_active, .o_reinit, .o_persist_req,
  .o_beacon_req_valid, .o_beacon_req, .o_survey_busy, .o_tx_valid,
  .o_tx_byte, .i_tx_ready);

// *** testbench/asc_radio_model.sv ***
/*
  behavioural radio and report byte sink facing the survey side of asc_top.
  assumes the bench sets mask and slow between surveys and reads the queues.
*/
`timescale 1ns/1ns
module asc_radio_model import asc_pkg::*; (
  // clock
  input wire logic i_sys_clk,
  // beacon side
  input wire logic i_req_valid,
  input wire asc_beacon_req_t i_req,
  output logic o_beacon_valid,
  output asc_record_t o_beacon_rec,
  // report byte sink
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_ready
);
  logic [11:0] mask = 12'h000;
  logic slow = 1'b0;
  logic [7:0] rx_q[$];
  logic [7:0] lane_q[$];
  int t_q[$];
  asc_record_t rec_q[$];
  int cyc = 0;
  logic [7:0] lane = 8'h00;
  logic pend = 1'b0;

  function automatic asc_record_t mk(logic [7:0] l);
    asc_record_t r;
    r = '0;
    r.coord_addr = {56'h0123456789abcd, l};
    r.network_number = {8'h33, l};
    r.coord_addr_format = l[0] ? 8'h03 : 8'h02;
    r.rf_lane_number = l;
    r.security_use = 8'h01;
    r.acl_entry = 8'h02;
    // a data byte equal to the separator must still pass through
    r.security_failure = 8'h0d;
    r.superframe = '{1'b1, l[0], 1'b0, 1'b1, l[3:0], 4'h5, 4'h2};
    r.gts_permit = 8'h01;
    r.rssi = 8'h40 + l;
    r.timestamp = {16'h1234, l};
    return r;
  endfunction

  initial begin
    o_beacon_valid = 1'b0;
    o_beacon_rec = '0;
    o_tx_ready = 1'b0;
  end

  always @(posedge i_sys_clk) begin
    cyc++;
    o_beacon_valid <= 1'b0;
    // idle record lines toggle so a stale record is never mistaken for data
    o_beacon_rec <= ~o_beacon_rec;
    o_tx_ready <= !slow || (cyc % 3 == 0);
    if (i_tx_valid && o_tx_ready)
      rx_q.push_back(i_tx_byte);
    pend <= i_req_valid;
    if (i_req_valid) begin
      lane_q.push_back(i_req.rf_lane_number);
      t_q.push_back(cyc);
      lane <= i_req.rf_lane_number;
    end
    if (pend && mask[lane - 8'h0c]) begin
      o_beacon_valid <= 1'b1;
      o_beacon_rec <= mk(lane);
      rec_q.push_back(mk(lane));
    end
  end
endmodule

// *** testbench/asc_top_tb.sv ***
/*
  self-checking bench for asc_top with a radio model on the survey side.
  assumes a dwell unit of 4 cycles so a survey takes a few hundred cycles.
*/
`timescale 1ns/1ns
module asc_top_tb import asc_pkg::*; ;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_cmd_valid = 1'b0;
  asc_cmd_req_t i_cmd = '0;
  logic i_join_valid = 1'b0;
  logic [7:0] i_join_code = 8'h00;
  logic o_rsp_valid, o_rsp_err, o_reinit, o_persist_req, o_beacon_req_valid;
  logic o_survey_busy, i_beacon_valid, o_tx_valid, i_tx_ready;
  logic [7:0] o_rsp_data, o_persist_opts, o_tx_byte, o_persist_framing;
  asc_active_t o_active;
  asc_beacon_req_t o_beacon_req;
  asc_record_t i_beacon_rec;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  asc_top #(.UNIT_CYCLES(4)) u_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_rsp_valid(o_rsp_valid),
    .o_rsp_err(o_rsp_err), .o_rsp_data(o_rsp_data), .o_active(o_active),
    .o_reinit(o_reinit), .o_persist_req(o_persist_req),
    .o_persist_opts(o_persist_opts), .o_persist_framing(o_persist_framing),
    .i_join_valid(i_join_valid), .i_join_code(i_join_code),
    .o_beacon_req_valid(o_beacon_req_valid), .o_beacon_req(o_beacon_req),
    .i_beacon_valid(i_beacon_valid), .i_beacon_rec(i_beacon_rec),
    .o_survey_busy(o_survey_busy), .o_tx_valid(o_tx_valid),
    .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready));

  asc_radio_model u_far (.i_sys_clk(i_sys_clk),
    .i_req_valid(o_beacon_req_valid), .i_req(o_beacon_req),
    .o_beacon_valid(i_beacon_valid), .o_beacon_rec(i_beacon_rec),
    .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte), .o_tx_ready(i_tx_ready));

  initial begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // last-resort limit; each survey wait loop already gives up after 4000 cycles
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cmd(asc_cmd_t c, logic [7:0] a, output logic e,
                     output logic [7:0] d);
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{code: c, arg: a};
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b0;
    #1;
    e = o_rsp_err;
    d = o_rsp_data;
    chk("rsp_valid", 1, o_rsp_valid);
  endtask

  function automatic void put(ref logic [7:0] q[$], input logic [63:0] v,
                              input int n, input logic api);
    for (int i = n - 1; i >= 0; i--)
      q.push_back(v[8*i+:8]);
    if (!api)
      q.push_back(8'h0d);
  endfunction

  function automatic void put_rec(ref logic [7:0] q[$], input asc_record_t r,
                                  input logic api);
    put(q, r.coord_addr, (r.coord_addr_format == 8'h03) ? 8 : 2, api);
    put(q, 64'(r.network_number), 2, api);
    put(q, 64'(r.coord_addr_format), 1, api);
    put(q, 64'(r.rf_lane_number), 1, api);
    put(q, 64'(r.security_use), 1, api);
    put(q, 64'(r.acl_entry), 1, api);
    put(q, 64'(r.security_failure), 1, api);
    put(q, 64'(r.superframe), 2, api);
    put(q, 64'(r.gts_permit), 1, api);
    put(q, 64'(r.rssi), 1, api);
    put(q, 64'(r.timestamp), 3, api);
  endfunction

  task automatic t_reset;
    logic e;
    logic [7:0] d;
    chk("active_rst", 0, o_active);
    cmd(ASC_CMD_RD_OPTS, 8'h00, e, d);
    chk("opts_rst", 0, d);
    cmd(ASC_CMD_RD_FRAMING, 8'h00, e, d);
    chk("framing_rst", 0, d);
    cmd(ASC_CMD_RD_RESULT, 8'h00, e, d);
    chk("result_rst", 0, d);
    cmd(ASC_CMD_SURVEY, 8'h07, e, d);
    chk("survey_arg_err", 1, e);
    $display("reset test done");
  endtask

  task automatic t_opts;
    logic e;
    logic [7:0] d;
    for (int v = 0; v < 8; v++) begin
      cmd(ASC_CMD_WR_OPTS, v[7:0], e, d);
      cmd(ASC_CMD_RD_OPTS, 8'h00, e, d);
      chk("opts", v, d);
      cmd(ASC_CMD_COMMIT, 8'h00, e, d);
      chk("reinit", 1, o_reinit);
      chk("active_opts", v, {o_active.permit_join_bit,
        o_active.pick_free_lane_bit, o_active.pick_free_network_bit});
    end
    cmd(ASC_CMD_WR_OPTS, 8'h0b, e, d);
    chk("rsvd_err", 1, e);
    cmd(ASC_CMD_RD_OPTS, 8'h00, e, d);
    chk("rsvd_read", 7, d);
    $display("options test done");
  endtask

  task automatic t_persist;
    logic e;
    logic [7:0] d;
    cmd(ASC_CMD_WR_OPTS, 8'h03, e, d);
    cmd(ASC_CMD_PERSIST, 8'h00, e, d);
    chk("persist_req", 1, o_persist_req);
    chk("persist_opts", 3, o_persist_opts);
    chk("persist_reinit", 0, o_reinit);
    chk("persist_held", 1, o_active.permit_join_bit);
    cmd(ASC_CMD_LEAVE, 8'h00, e, d);
    chk("leave_applied", 0, o_active.permit_join_bit);
    $display("persist test done");
  endtask

  task automatic t_result;
    logic e;
    logic [7:0] d;
    logic [7:0] last;
    last = 8'h00;
    for (int c = 0; c < 22; c++) begin
      @(posedge i_sys_clk);
      i_join_valid <= 1'b1;
      i_join_code <= c[7:0];
      @(posedge i_sys_clk);
      i_join_valid <= 1'b0;
      if (c <= 'h13 && c != 'h11)
        last = c[7:0];
      cmd(ASC_CMD_RD_RESULT, 8'h00, e, d);
      chk("result", last, d);
    end
    $display("result test done");
  endtask

  task automatic t_framing;
    logic e;
    logic [7:0] d;
    cmd(ASC_CMD_WR_FRAMING, 8'h03, e, d);
    chk("framing_err", 1, e);
    cmd(ASC_CMD_WR_FRAMING, 8'h02, e, d);
    cmd(ASC_CMD_RD_FRAMING, 8'h00, e, d);
    chk("framing_rd", 2, d);
    cmd(ASC_CMD_WR_FRAMING, 8'h01, e, d);
    cmd(ASC_CMD_COMMIT, 8'h00, e, d);
    chk("framing_act", 1, o_active.host_framing_select);
    cmd(ASC_CMD_PERSIST, 8'h00, e, d);
    chk("persist_framing", 1, o_persist_framing);
    $display("framing test done");
  endtask

  task automatic t_survey(logic [7:0] a, logic [11:0] m, logic slow,
                          logic api);
    logic e;
    logic [7:0] d;
    logic [7:0] q[$];
    int dw;
    u_far.mask = m;
    u_far.slow = slow;
    u_far.rx_q.delete();
    u_far.lane_q.delete();
    u_far.t_q.delete();
    u_far.rec_q.delete();
    cmd(ASC_CMD_SURVEY, a, e, d);
    chk("survey_err", 0, e);
    cmd(ASC_CMD_RD_OPTS, 8'h00, e, d);
    chk("busy_refuse", 1, e);
    for (int i = 0; i < 4000 && (o_survey_busy || o_tx_valid); i++)
      @(posedge i_sys_clk);
    repeat (4) @(posedge i_sys_clk);
    chk("lanes", 12, u_far.lane_q.size());
    for (int i = 0; i < u_far.lane_q.size(); i++)
      chk("lane", 8'h0c + i, u_far.lane_q[i]);
    dw = (1 << a) * 4;
    chk("span", 1, (u_far.t_q[11] - u_far.t_q[0]) inside
      {[11 * dw:11 * (dw + 3)]});
    for (int i = 0; i < u_far.rec_q.size() && i < 5; i++)
      put_rec(q, u_far.rec_q[i], api);
    if (!api)
      q.push_back(8'h0d);
    chk("byte_count", q.size(), u_far.rx_q.size());
    for (int i = 0; i < q.size(); i++)
      chk("byte", q[i], u_far.rx_q[i]);
    $display("survey test done");
  endtask

  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    t_reset();
    t_opts();
    t_persist();
    t_result();
    t_survey(8'h00, 12'h0fe, 1'b1, 1'b0);
    t_framing();
    t_survey(8'h01, 12'h801, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule
